// >>> hdl/energy_detect_power_control.sv
// Energy-detect power controller for one transceiver port
//
// Operation
// - Power management acts only while enable is set; enable resets from strap.
// - Automatic power-up starts once data events reach the data threshold.
// - Automatic power-down starts when no energy is seen on the line.
// - Writing one to manual toggle flips power state; bit self-clears.
// - Each power-up sends four detect pulses, or one when bursts disabled.
// - Power-state bit reads one when powered up, zero when down.
// - Error-met flag sets at error threshold, no action, cleared by read.
// - Data-met flag sets when data events reach threshold, cleared by read.
// - Four-bit error threshold field, read-write, resets to one.
// - Four-bit data threshold field, read-write, resets to one.
// - Both counters clear after about two seconds without data events.
// - Control and status register sits at management address 1Dh.
`timescale 1ns/100ps
`default_nettype none
module energy_detect_power_control
    import edpc_pkg::*;
#(
    parameter int unsigned QUIET_CYCLES = QUIET_CYCLES_DEF
) (
    input wire logic sys_clk_i,
    input wire logic srst_i,
    input wire logic strap_enable_i,
    input wire logic line_data_event_i,
    input wire logic line_error_event_i,
    input wire logic line_energy_i,
    input wire logic [4:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [15:0] reg_wdata_i,
    output logic [15:0] reg_rdata_o,
    output logic reg_rvalid_o,
    output logic port_powered_o,
    output logic detect_pulse_o
);

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    logic strap_lvl;
    logic data_ev;
    logic err_ev;
    logic energy_lvl;

    pin_sync u_strap_sync (
        .sys_clk_i(sys_clk_i),
        .srst_i(srst_i),
        .pin_i(strap_enable_i),
        .level_o(strap_lvl),
        .rise_o()
    );

    pin_sync u_data_sync (
        .sys_clk_i(sys_clk_i),
        .srst_i(srst_i),
        .pin_i(line_data_event_i),
        .level_o(),
        .rise_o(data_ev)
    );

    pin_sync u_err_sync (
        .sys_clk_i(sys_clk_i),
        .srst_i(srst_i),
        .pin_i(line_error_event_i),
        .level_o(),
        .rise_o(err_ev)
    );

    pin_sync u_energy_sync (
        .sys_clk_i(sys_clk_i),
        .srst_i(srst_i),
        .pin_i(line_energy_i),
        .level_o(energy_lvl),
        .rise_o()
    );

    ////////////////////////////////////////////////////////////////////////
    // Register state
    logic enable_q;
    logic auto_up_q;
    logic auto_down_q;
    logic manual_q;
    logic burst_dis_q;
    logic err_met_q;
    logic data_met_q;
    logic [3:0] err_thr_q;
    logic [3:0] data_thr_q;
    logic [15:0] rdata_q;
    logic rvalid_q;

    // Counters and state machine
    logic [3:0] data_cnt_q;
    logic [3:0] data_cnt_d;
    logic [3:0] err_cnt_q;
    logic [3:0] err_cnt_d;
    logic [QUIET_W-1:0] quiet_cnt_q;
    power_state_t state_q;
    power_state_t state_d;
    logic [2:0] pulses_q;
    logic [3:0] gap_q;
    logic powered_q;
    logic pulse_q;

    ////////////////////////////////////////////////////////////////////////
    // Access decode
    wire hit = (reg_addr_i == ESCS_ADDR);
    wire wr_hit = reg_wr_i && hit;
    wire rd_hit = reg_rd_i && hit;
    wire [QUIET_W-1:0] quiet_last = QUIET_W'(QUIET_CYCLES - 32'd1);
    wire quiet_done = (quiet_cnt_q == quiet_last);
    wire data_reached = thr_met(data_cnt_q, data_thr_q);
    // Flags set on the event that meets a threshold, so a read clears them
    wire data_hit = data_ev && thr_met(data_cnt_d, data_thr_q);
    wire err_hit = err_ev && thr_met(err_cnt_d, err_thr_q);
    wire pwr_state = (state_q != ST_DOWN);
    wire [2:0] pulse_target = burst_dis_q ? SINGLE_PULSES : BURST_PULSES;
    wire gap_end = (gap_q == PULSE_GAP_CYCLES);
    wire burst_end = gap_end && (pulses_q == pulse_target);
    wire going_up = (state_q == ST_DOWN) && (state_d == ST_BURST);

    // Read image of the register
    wire [15:0] image = {enable_q, auto_up_q, auto_down_q, manual_q,
                         burst_dis_q, pwr_state, err_met_q, data_met_q,
                         err_thr_q, data_thr_q};

    ////////////////////////////////////////////////////////////////////////
    // Read-write fields; enable reloads from strap during reset
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            enable_q <= strap_lvl;
            auto_up_q <= AUTO_UP_RST;
            auto_down_q <= AUTO_DOWN_RST;
            burst_dis_q <= BURST_DIS_RST;
            err_thr_q <= ERR_THR_RST;
            data_thr_q <= DATA_THR_RST;
        end else if (wr_hit) begin
            enable_q <= reg_wdata_i[ENABLE_BIT];
            auto_up_q <= reg_wdata_i[AUTO_UP_BIT];
            auto_down_q <= reg_wdata_i[AUTO_DOWN_BIT];
            burst_dis_q <= reg_wdata_i[BURST_DIS_BIT];
            err_thr_q <= reg_wdata_i[ERR_THR_MSB:ERR_THR_LSB];
            data_thr_q <= reg_wdata_i[DATA_THR_MSB:DATA_THR_LSB];
        end
    end

    // Self-clearing manual toggle, one cycle wide
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            manual_q <= 1'b0;
        end else begin
            manual_q <= wr_hit && reg_wdata_i[MANUAL_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sticky threshold flags, set beats the clear on read
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            err_met_q <= 1'b0;
            data_met_q <= 1'b0;
        end else begin
            err_met_q <= err_hit || (err_met_q && !rd_hit);
            data_met_q <= data_hit || (data_met_q && !rd_hit);
        end
    end

    // Registered read answer
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            rdata_q <= 16'h0000;
            rvalid_q <= 1'b0;
        end else begin
            rvalid_q <= reg_rd_i;
            if (reg_rd_i) begin
                rdata_q <= hit ? image : 16'h0000;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Event counters: saturate, clear after quiet time or on power-up
    // An event in the quiet expiry cycle still counts after the clear
    always_comb begin
        data_cnt_d = quiet_done ? 4'h0 : data_cnt_q;
        err_cnt_d = quiet_done ? 4'h0 : err_cnt_q;
        if (going_up) begin
            data_cnt_d = 4'h0;
            err_cnt_d = 4'h0;
        end else begin
            if (data_ev) begin
                data_cnt_d = sat_inc(data_cnt_d);
            end
            if (err_ev) begin
                err_cnt_d = sat_inc(err_cnt_d);
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            data_cnt_q <= 4'h0;
            err_cnt_q <= 4'h0;
        end else begin
            data_cnt_q <= data_cnt_d;
            err_cnt_q <= err_cnt_d;
        end
    end

    // Quiet timer restarts on every data event
    always_ff @(posedge sys_clk_i) begin
        if (srst_i || data_ev || quiet_done) begin
            quiet_cnt_q <= '0;
        end else begin
            quiet_cnt_q <= quiet_cnt_q + QUIET_W'(1);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Power state machine; held up while the feature is disabled
    always_comb begin
        state_d = state_q;
        if (!enable_q) begin
            state_d = ST_UP;
        end else begin
            case (state_q)
                ST_DOWN: begin
                    if (manual_q) begin
                        state_d = ST_BURST;
                    end else if (auto_up_q && data_reached) begin
                        state_d = ST_BURST;
                    end
                end
                ST_BURST: begin
                    if (manual_q) begin
                        state_d = ST_DOWN;
                    end else if (burst_end) begin
                        state_d = ST_UP;
                    end
                end
                ST_UP: begin
                    if (manual_q) begin
                        state_d = ST_DOWN;
                    end else if (auto_down_q && !energy_lvl) begin
                        state_d = ST_DOWN;
                    end
                end
                default: begin
                    state_d = ST_DOWN;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            state_q <= ST_UP;
        end else begin
            state_q <= state_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Detect pulse burst: one pulse, then a gap, per count
    always_ff @(posedge sys_clk_i) begin
        if (srst_i || state_d != ST_BURST) begin
            pulses_q <= 3'h0;
            gap_q <= 4'h0;
            pulse_q <= 1'b0;
        end else begin
            pulse_q <= (gap_q == 4'h0) && (pulses_q != pulse_target);
            if (gap_end) begin
                gap_q <= 4'h0;
            end else begin
                gap_q <= gap_q + 4'h1;
            end
            if (gap_q == 4'h0 && pulses_q != pulse_target) begin
                pulses_q <= pulses_q + 3'h1;
            end
        end
    end

    // Port power output
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            powered_q <= 1'b1;
        end else begin
            powered_q <= (state_d != ST_DOWN);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs
    assign reg_rdata_o = rdata_q;
    assign reg_rvalid_o = rvalid_q;
    assign port_powered_o = powered_q;
    assign detect_pulse_o = pulse_q;

endmodule : energy_detect_power_control
`default_nettype wire

// >>> inc/edpc_pkg.sv
// Constants, types and helpers for the energy-detect power controller
package edpc_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Register address and field positions
    localparam logic [4:0] ESCS_ADDR = 5'h1D;
    localparam int ENABLE_BIT = 15;
    localparam int AUTO_UP_BIT = 14;
    localparam int AUTO_DOWN_BIT = 13;
    localparam int MANUAL_BIT = 12;
    localparam int BURST_DIS_BIT = 11;
    localparam int PWR_STATE_BIT = 10;
    localparam int ERR_MET_BIT = 9;
    localparam int DATA_MET_BIT = 8;
    localparam int ERR_THR_MSB = 7;
    localparam int ERR_THR_LSB = 4;
    localparam int DATA_THR_MSB = 3;
    localparam int DATA_THR_LSB = 0;

    ////////////////////////////////////////////////////////////////////////
    // Reset values
    localparam logic AUTO_UP_RST = 1'b1;
    localparam logic AUTO_DOWN_RST = 1'b1;
    localparam logic BURST_DIS_RST = 1'b0;
    localparam logic [3:0] ERR_THR_RST = 4'h1;
    localparam logic [3:0] DATA_THR_RST = 4'h1;

    ////////////////////////////////////////////////////////////////////////
    // Pulse burst shape
    localparam logic [2:0] BURST_PULSES = 3'h4;
    localparam logic [2:0] SINGLE_PULSES = 3'h1;
    localparam logic [3:0] PULSE_GAP_CYCLES = 4'hF;

    ////////////////////////////////////////////////////////////////////////
    // Quiet time before both event counters are cleared
    localparam int unsigned CLK_MHZ = 200;
    localparam int unsigned QUIET_TIME_S = 2;
    localparam int unsigned QUIET_CYCLES_DEF = QUIET_TIME_S * CLK_MHZ * 1000000;
    localparam int QUIET_W = 29;

    ////////////////////////////////////////////////////////////////////////
    // Power state machine
    typedef enum logic [1:0] {
        ST_DOWN = 2'b00,
        ST_BURST = 2'b01,
        ST_UP = 2'b10
    } power_state_t;

    // Saturating four-bit increment
    function automatic logic [3:0] sat_inc(input logic [3:0] v);
        sat_inc = (v == 4'hF) ? v : v + 4'h1;
    endfunction : sat_inc

    // Threshold reached test
    function automatic logic thr_met(input logic [3:0] cnt,
                                     input logic [3:0] thr);
        thr_met = (cnt >= thr);
    endfunction : thr_met

endpackage : edpc_pkg

// >>> hdl/pin_sync.sv
// Three-stage pin synchroniser with agreement filter and rise pulse
`timescale 1ns/100ps
`default_nettype none
module pin_sync (
    input wire logic sys_clk_i,
    input wire logic srst_i,
    input wire logic pin_i,
    output logic level_o,
    output logic rise_o
);

    logic s1_q;
    logic s2_q;
    logic s3_q;
    logic level_q;
    logic rise_q;
    wire agree = (s2_q == s3_q);

    // Shift chain, first stage read only by the second
    always_ff @(posedge sys_clk_i) begin
        s1_q <= pin_i;
        s2_q <= s1_q;
        s3_q <= s2_q;
    end

    // Level tracks the pin through reset: strap settled, no false edge
    always_ff @(posedge sys_clk_i) begin
        if (agree) begin
            level_q <= s3_q;
        end
        if (srst_i) begin
            rise_q <= 1'b0;
        end else begin
            rise_q <= agree && s3_q && !level_q;
        end
    end

    assign level_o = level_q;
    assign rise_o = rise_q;

endmodule : pin_sync
`default_nettype wire

// >>> test/energy_detect_power_control_chk.sv
// Port checker for the energy-detect power controller
`timescale 1ns/100ps
`default_nettype none
module energy_detect_power_control_chk
    import edpc_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic srst_i,
    input wire logic [4:0] reg_addr_i,
    input wire logic reg_rd_i,
    input wire logic [15:0] reg_rdata_o,
    input wire logic reg_rvalid_o,
    input wire logic port_powered_o,
    input wire logic detect_pulse_o
);
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (srst_i);

    ////////////////////////////////////////////////////////////////////////
    // Register access timing and contents
    a_rvalid_after_read: assert property (reg_rd_i |=> reg_rvalid_o)
        else $error("read not answered one cycle later");
    a_rvalid_needs_read: assert property (reg_rvalid_o |-> $past(reg_rd_i))
        else $error("read valid without a read");
    a_unmapped_zero: assert property (
        reg_rd_i && reg_addr_i != ESCS_ADDR |=> reg_rdata_o == 16'h0000)
        else $error("unmapped read not zero");
    a_rdata_holds: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
        else $error("read data moved without a read");
    a_state_bit_match: assert property (
        reg_rvalid_o && reg_rdata_o[ENABLE_BIT]
        |-> reg_rdata_o[PWR_STATE_BIT] == $past(port_powered_o))
        else $error("power state bit disagrees with power");
    a_disabled_powered: assert property (
        reg_rvalid_o && !reg_rdata_o[ENABLE_BIT] |-> port_powered_o)
        else $error("port unpowered while disabled");

    ////////////////////////////////////////////////////////////////////////
    // Detect pulse shape
    a_pulse_spacing: assert property (
        detect_pulse_o |=> !detect_pulse_o [*8])
        else $error("detect pulses too close");
    a_pulse_powered: assert property (detect_pulse_o |-> port_powered_o)
        else $error("detect pulse while powered down");

    c_pulse: cover property (detect_pulse_o);
    c_power_up: cover property ($rose(port_powered_o));
    c_power_down: cover property ($fell(port_powered_o));
endmodule : energy_detect_power_control_chk

bind energy_detect_power_control energy_detect_power_control_chk i_chk (
    .sys_clk_i(sys_clk_i),
    .srst_i(srst_i),
    .reg_addr_i(reg_addr_i),
    .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o),
    .reg_rvalid_o(reg_rvalid_o),
    .port_powered_o(port_powered_o),
    .detect_pulse_o(detect_pulse_o)
);
`default_nettype wire

// >>> test/link_partner_model.sv
// Cable link partner: drives events and energy, counts pulses
`timescale 1ns/100ps
`default_nettype none
module link_partner_model (
    input wire logic sys_clk_i,
    input wire logic detect_pulse_i,
    output logic data_event_o,
    output logic error_event_o,
    output logic energy_o
);
    int pulse_count = 0;

    // Quiet cable with energy present
    initial begin
        data_event_o = 1'b0;
        error_event_o = 1'b0;
        energy_o = 1'b1;
    end

    // Count detect pulses arriving over the cable
    always @(posedge sys_clk_i) begin
        if (detect_pulse_i === 1'b1) begin
            pulse_count <= pulse_count + 1;
        end
    end

    // Events with low gaps so each one is counted apart
    task automatic send(input int n, input bit err);
        for (int i = 0; i < n; i++) begin
            @(posedge sys_clk_i) #1;
            {error_event_o, data_event_o} = err ? 2'b10 : 2'b01;
            repeat (6) @(posedge sys_clk_i);
            #1 {error_event_o, data_event_o} = 2'b00;
            repeat (6) @(posedge sys_clk_i);
        end
    endtask : send

    // Energy level on the line
    task automatic set_energy(input logic v);
        @(posedge sys_clk_i) #1;
        energy_o = v;
    endtask : set_energy
endmodule : link_partner_model
`default_nettype wire

// >>> test/energy_detect_power_control_tb.sv
// Testbench for the energy-detect power controller
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, a) \
    begin \
        total_checks++; \
        if ((a) !== (e)) begin \
            n_mismatch++; \
            $display("[FAIL] %s expected %h seen %h", nm, e, a); \
        end \
    end
module energy_detect_power_control_tb
    import edpc_pkg::*;
;
    logic sys_clk_i, srst_i, strap_enable_i, reg_wr_i, reg_rd_i;
    logic data_ev, err_ev, energy, reg_rvalid_o, port_powered_o, pulse;
    logic [4:0] reg_addr_i;
    logic [15:0] reg_wdata_i, reg_rdata_o;
    int n_mismatch = 0;
    int total_checks = 0;

    energy_detect_power_control #(.QUIET_CYCLES(64)) i_energy_detect_power_control (
        .sys_clk_i(sys_clk_i), .srst_i(srst_i),
        .strap_enable_i(strap_enable_i), .line_data_event_i(data_ev),
        .line_error_event_i(err_ev), .line_energy_i(energy),
        .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
        .reg_rvalid_o(reg_rvalid_o), .port_powered_o(port_powered_o),
        .detect_pulse_o(pulse)
    );

    link_partner_model i_link_partner_model (
        .sys_clk_i(sys_clk_i), .detect_pulse_i(pulse),
        .data_event_o(data_ev), .error_event_o(err_ev), .energy_o(energy)
    );

    // 200 MHz clock
    always #2.5 sys_clk_i = ~sys_clk_i;

    ////////////////////////////////////////////////////////////////////////
    // Register access tasks
    task automatic rdc(input logic [4:0] a, input logic [15:0] e);
        @(posedge sys_clk_i) #1;
        reg_rd_i = 1'b1;
        reg_addr_i = a;
        @(posedge sys_clk_i) #1;
        reg_rd_i = 1'b0;
        `CHK("read valid", 1'b1, reg_rvalid_o)
        `CHK("read data", e, reg_rdata_o)
    endtask : rdc

    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge sys_clk_i) #1;
        reg_wr_i = 1'b1;
        reg_addr_i = a;
        reg_wdata_i = d;
        @(posedge sys_clk_i) #1;
        reg_wr_i = 1'b0;
    endtask : wr

    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk_i);
        #1;
    endtask : cyc

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : tally_and_finish

    ////////////////////////////////////////////////////////////////////////
    // Test sequence
    initial begin
        int p;
        sys_clk_i = 1'b0;
        srst_i = 1'b1;
        strap_enable_i = 1'b1;
        reg_addr_i = 5'h00;
        reg_wr_i = 1'b0;
        reg_rd_i = 1'b0;
        reg_wdata_i = 16'h0000;
        repeat (8) @(posedge sys_clk_i);
        #1 srst_i = 1'b0;
        // Reset image, unmapped access, read-only bits
        rdc(ESCS_ADDR, 16'hE411);
        rdc(5'h1C, 16'h0000);
        wr(5'h1C, 16'h0000);
        wr(ESCS_ADDR, 16'hE711);
        rdc(ESCS_ADDR, 16'hE411);
        $display("test reset image done");
        // No energy powers the port down
        i_link_partner_model.set_energy(1'b0);
        cyc(10);
        `CHK("powered", 1'b0, port_powered_o)
        rdc(ESCS_ADDR, 16'hE011);
        $display("test auto down done");
        // Data threshold of three starts a four pulse burst
        wr(ESCS_ADDR, 16'hE013);
        i_link_partner_model.send(2, 1'b0);
        rdc(ESCS_ADDR, 16'hE013);
        i_link_partner_model.set_energy(1'b1);
        p = i_link_partner_model.pulse_count;
        i_link_partner_model.send(1, 1'b0);
        cyc(80);
        `CHK("pulses", 4, i_link_partner_model.pulse_count - p)
        rdc(ESCS_ADDR, 16'hE513);
        rdc(ESCS_ADDR, 16'hE413);
        $display("test auto up done");
        // Manual toggle down then up, single pulse
        wr(ESCS_ADDR, 16'hF813);
        cyc(4);
        `CHK("powered", 1'b0, port_powered_o)
        rdc(ESCS_ADDR, 16'hE813);
        p = i_link_partner_model.pulse_count;
        wr(ESCS_ADDR, 16'hF813);
        cyc(40);
        `CHK("pulses", 1, i_link_partner_model.pulse_count - p)
        `CHK("powered", 1'b1, port_powered_o)
        rdc(ESCS_ADDR, 16'hEC13);
        $display("test manual done");
        // Error threshold flag, no power action
        wr(ESCS_ADDR, 16'hE823);
        i_link_partner_model.send(1, 1'b0);
        i_link_partner_model.send(2, 1'b1);
        rdc(ESCS_ADDR, 16'hEE23);
        rdc(ESCS_ADDR, 16'hEC23);
        $display("test error flag done");
        // Quiet time clears the counters
        wr(ESCS_ADDR, 16'hE822);
        cyc(100);
        i_link_partner_model.send(1, 1'b0);
        cyc(100);
        i_link_partner_model.send(1, 1'b0);
        rdc(ESCS_ADDR, 16'hEC22);
        i_link_partner_model.send(1, 1'b0);
        rdc(ESCS_ADDR, 16'hED22);
        $display("test quiet timer done");
        // Disabled: forced powered, manual ignored
        wr(ESCS_ADDR, 16'h6822);
        i_link_partner_model.set_energy(1'b0);
        cyc(10);
        `CHK("powered", 1'b1, port_powered_o)
        rdc(ESCS_ADDR, 16'h6C22);
        wr(ESCS_ADDR, 16'h7822);
        cyc(4);
        `CHK("powered", 1'b1, port_powered_o)
        $display("test disable done");
        tally_and_finish();
    end
endmodule : energy_detect_power_control_tb
`default_nettype wire
